// *** rtl/gpio_evt_defs.vh ***
`ifndef GPIO_EVT_DEFS_VH
`define GPIO_EVT_DEFS_VH

// Register word offsets within one port, byte addresses
`define OFS_OWNERSHIP     8'h00
`define OFS_FUNC_LOW      8'h10
`define OFS_FUNC_HIGH     8'h20
`define OFS_DRIVER_ON     8'h40
`define OFS_OUT_LEVEL     8'h50
`define OFS_PIN_VALUE     8'h60
`define OFS_PULLUP        8'h70
`define OFS_IRQ_ENABLE    8'h90
`define OFS_KIND_LOW      8'ha0
`define OFS_KIND_HIGH     8'hb0
`define OFS_FILTER_EN     8'hc0
`define OFS_EVENT_FLAGS   8'hd0
`define OFS_EVENT_CLEAR   8'hd8
`define OFS_IRQ_STATUS    8'he0
`define OFS_IRQ_MASK      8'he4
// Port select bit within the byte address
`define PORT_SEL_BIT      9
// Access sub-word: 0 write, 1 set, 2 clear, 3 toggle
`define ACC_WRITE         2'h0
`define ACC_SET           2'h1
`define ACC_CLEAR         2'h2
`define ACC_TOGGLE        2'h3
// Reset values
`define RST_ZERO          32'h00000000
`define RST_PORT0_OWN     32'hffffffff
`define RST_PORT0_FLAGS   32'hffffffff
`define RST_PORT1_OWN     32'h00000fff
`define RST_PORT1_FLAGS   32'h00000fff
// Event kinds
`define KIND_CHANGE       2'h0
`define KIND_RISE         2'h1
`define KIND_FALL         2'h2
// Summary status bit positions
`define STAT_PORT0        0
`define STAT_PORT1        1
// Filter length in module clocks
`define FILTER_CYCLES     3

`endif

// *** rtl/pin_glitch_filter.v ***
`timescale 1ns/1ps
// Per-pin filter: output follows input only after it held steady
module pin_glitch_filter #(
  parameter WIDTH  = 32,
  parameter CYCLES = 3
) (
  input  wire             clock_i,
  input  wire             arst_n_i,
  input  wire [WIDTH-1:0] pin_i,
  input  wire [WIDTH-1:0] enable_i,
  output wire [WIDTH-1:0] pin_o
);

  reg  [WIDTH-1:0] stable_reg;
  reg  [1:0]       count_reg [0:WIDTH-1];
  reg  [WIDTH-1:0] raw_reg;
  integer          k;

  // Raw sample taken every cycle; bypass path uses it directly
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      raw_reg <= {WIDTH{1'b0}};
      stable_reg <= {WIDTH{1'b0}};
      for (k = 0; k < WIDTH; k = k + 1)
        count_reg[k] <= 2'h0;
    end else begin
      raw_reg <= pin_i;
      for (k = 0; k < WIDTH; k = k + 1) begin
        if (raw_reg[k] == stable_reg[k]) begin
          count_reg[k] <= 2'h0;
        end else if (count_reg[k] == CYCLES[1:0] - 2'h1) begin
          // Pulses shorter than CYCLES clocks never get here
          stable_reg[k] <= raw_reg[k];
          count_reg[k] <= 2'h0;
        end else begin
          count_reg[k] <= count_reg[k] + 2'h1;
        end
      end
    end
  end

  // Filtered or raw per pin
  assign pin_o = (enable_i & stable_reg) | (~enable_i & raw_reg);

endmodule

// *** rtl/gpio_pin_event.v ***
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "gpio_evt_defs.vh"
module gpio_pin_event #(
  parameter WIDTH = 32
) (
  input  wire             clock_i,
  input  wire             arst_n_i,
  input  wire [9:0]       avs_address_i,
  input  wire             avs_read_i,
  input  wire             avs_write_i,
  input  wire [31:0]      avs_writedata_i,
  output reg  [31:0]      avs_readdata_o,
  output reg              avs_waitrequest_o,
  input  wire [WIDTH-1:0] pin0_i,
  input  wire [WIDTH-1:0] pin1_i,
  output reg  [WIDTH-1:0] pin0_out_o,
  output reg  [WIDTH-1:0] pin0_oe_o,
  output reg  [WIDTH-1:0] pin0_pullup_o,
  output reg  [WIDTH-1:0] pin0_gpio_own_o,
  output reg  [WIDTH-1:0] pin0_func_low_o,
  output reg  [WIDTH-1:0] pin0_func_high_o,
  output reg  [WIDTH-1:0] pin1_out_o,
  output reg  [WIDTH-1:0] pin1_oe_o,
  output reg  [WIDTH-1:0] pin1_pullup_o,
  output reg  [WIDTH-1:0] pin1_gpio_own_o,
  output reg  [WIDTH-1:0] pin1_func_low_o,
  output reg  [WIDTH-1:0] pin1_func_high_o,
  output reg  [WIDTH-1:0] pin0_irq_o,
  output reg  [WIDTH-1:0] pin1_irq_o,
  output reg              irq_o
);

  // Per-port register arrays, index 0 and 1
  reg  [WIDTH-1:0] port_ownership_enable [0:1];
  reg  [WIDTH-1:0] function_select_low   [0:1];
  reg  [WIDTH-1:0] function_select_high  [0:1];
  reg  [WIDTH-1:0] output_driver_on      [0:1];
  reg  [WIDTH-1:0] output_level          [0:1];
  reg  [WIDTH-1:0] pullup_on             [0:1];
  reg  [WIDTH-1:0] pin_irq_enable        [0:1];
  reg  [WIDTH-1:0] event_kind_low        [0:1];
  reg  [WIDTH-1:0] event_kind_high       [0:1];
  reg  [WIDTH-1:0] input_filter_enable   [0:1];
  reg  [WIDTH-1:0] pin_event_flags       [0:1];
  reg  [WIDTH-1:0] prev_level_reg        [0:1];
  reg  [1:0]       irq_status_reg;
  reg  [1:0]       irq_mask_reg;
  reg              ack_reg;
  wire [WIDTH-1:0] filt0;
  wire [WIDTH-1:0] filt1;
  wire [WIDTH-1:0] filt         [0:1];
  wire [WIDTH-1:0] detect       [0:1];
  wire [WIDTH-1:0] clear_mask   [0:1];
  wire             port_sel;
  wire [7:0]       word_ofs;
  wire [1:0]       acc_kind;
  wire             bus_write;
  wire [WIDTH-1:0] wdata;
  integer          p;

  assign port_sel  = avs_address_i[`PORT_SEL_BIT];
  assign word_ofs  = {avs_address_i[7:4], 4'h0};
  assign acc_kind  = avs_address_i[3:2];
  assign bus_write = avs_write_i & ack_reg; // Lands on the edge the answer is seen
  assign wdata     = avs_writedata_i[WIDTH-1:0];

  // Write, set, clear or toggle applied to one register
  function [WIDTH-1:0] apply_access;
    input [WIDTH-1:0] cur;
    input [WIDTH-1:0] val;
    input [1:0]       kind;
    begin
      case (kind)
        `ACC_WRITE:  apply_access = val;
        `ACC_SET:    apply_access = cur | val;
        `ACC_CLEAR:  apply_access = cur & ~val;
        `ACC_TOGGLE: apply_access = cur ^ val;
        default:     apply_access = cur;
      endcase
    end
  endfunction

  // Edge detection per kind; reserved kind detects nothing
  function [WIDTH-1:0] detect_kind;
    input [WIDTH-1:0] now;
    input [WIDTH-1:0] was;
    input [WIDTH-1:0] kl;
    input [WIDTH-1:0] kh;
    begin
      detect_kind = (~kh & ~kl & (now ^ was))
                  | (~kh &  kl & now & ~was)
                  | ( kh & ~kl & ~now & was);
    end
  endfunction

  // One filter per port, filtered before edge detection
  pin_glitch_filter #(
    .WIDTH  (WIDTH),
    .CYCLES (`FILTER_CYCLES)
  ) u_filt0 (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .pin_i    (pin0_i),
    .enable_i (input_filter_enable[0]),
    .pin_o    (filt0)
  );

  pin_glitch_filter #(
    .WIDTH  (WIDTH),
    .CYCLES (`FILTER_CYCLES)
  ) u_filt1 (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .pin_i    (pin1_i),
    .enable_i (input_filter_enable[1]),
    .pin_o    (filt1)
  );

  assign filt[0] = filt0;
  assign filt[1] = filt1;

  // Detection gated by enable so disabled pins stay silent
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : port_logic
      assign detect[g] = pin_irq_enable[g] &
                         detect_kind(filt[g], prev_level_reg[g],
                                     event_kind_low[g], event_kind_high[g]);
      assign clear_mask[g] = (bus_write && port_sel == g
                              && word_ofs == `OFS_EVENT_FLAGS
                              && avs_address_i[3:2] == 2'h2) ? wdata : {WIDTH{1'b0}};
    end
  endgenerate

  // Register bank; single cycle wait then answer
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port_ownership_enable[0] <= `RST_PORT0_OWN;
      port_ownership_enable[1] <= `RST_PORT1_OWN;
      pin_event_flags[0]       <= `RST_PORT0_FLAGS;
      pin_event_flags[1]       <= `RST_PORT1_FLAGS;
      for (p = 0; p < 2; p = p + 1) begin
        function_select_low[p]  <= `RST_ZERO;
        function_select_high[p] <= `RST_ZERO;
        output_driver_on[p]     <= `RST_ZERO;
        output_level[p]         <= `RST_ZERO;
        pullup_on[p]            <= `RST_ZERO;
        pin_irq_enable[p]       <= `RST_ZERO;
        event_kind_low[p]       <= `RST_ZERO;
        event_kind_high[p]      <= `RST_ZERO;
        input_filter_enable[p]  <= `RST_ZERO;
        prev_level_reg[p]       <= `RST_ZERO;
      end
      irq_status_reg <= 2'h0;
      irq_mask_reg   <= 2'h0;
      ack_reg        <= 1'b0;
    end else begin
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
      for (p = 0; p < 2; p = p + 1) begin
        prev_level_reg[p] <= filt[p];
        // Set beats clear in the same cycle; reading zero is exact
        pin_event_flags[p] <= (pin_event_flags[p] & ~clear_mask[p])
                              | detect[p];
      end
      if (bus_write && word_ofs != `OFS_EVENT_FLAGS) begin
        case (word_ofs)
          `OFS_OWNERSHIP: port_ownership_enable[port_sel] <=
            apply_access(port_ownership_enable[port_sel], wdata, acc_kind);
          `OFS_FUNC_LOW: function_select_low[port_sel] <=
            apply_access(function_select_low[port_sel], wdata, acc_kind);
          `OFS_FUNC_HIGH: function_select_high[port_sel] <=
            apply_access(function_select_high[port_sel], wdata, acc_kind);
          `OFS_DRIVER_ON: output_driver_on[port_sel] <=
            apply_access(output_driver_on[port_sel], wdata, acc_kind);
          `OFS_OUT_LEVEL: output_level[port_sel] <=
            apply_access(output_level[port_sel], wdata, acc_kind);
          `OFS_PULLUP: pullup_on[port_sel] <=
            apply_access(pullup_on[port_sel], wdata, acc_kind);
          `OFS_IRQ_ENABLE: pin_irq_enable[port_sel] <=
            apply_access(pin_irq_enable[port_sel], wdata, acc_kind);
          `OFS_KIND_LOW: event_kind_low[port_sel] <=
            apply_access(event_kind_low[port_sel], wdata, acc_kind);
          `OFS_KIND_HIGH: event_kind_high[port_sel] <=
            apply_access(event_kind_high[port_sel], wdata, acc_kind);
          // Spurious events possible if changed with interrupt on
          `OFS_FILTER_EN: input_filter_enable[port_sel] <=
            apply_access(input_filter_enable[port_sel], wdata, acc_kind);
          default: ;
        endcase
      end
      // Summary status: per-port event sticky, write one to clear, set wins
      irq_status_reg[`STAT_PORT0] <= (|detect[0]) |
        (irq_status_reg[`STAT_PORT0] &
         ~(bus_write && avs_address_i[7:0] == `OFS_IRQ_STATUS
           && avs_writedata_i[`STAT_PORT0]));
      irq_status_reg[`STAT_PORT1] <= (|detect[1]) |
        (irq_status_reg[`STAT_PORT1] &
         ~(bus_write && avs_address_i[7:0] == `OFS_IRQ_STATUS
           && avs_writedata_i[`STAT_PORT1]));
      if (bus_write && avs_address_i[7:0] == `OFS_IRQ_MASK)
        irq_mask_reg <= avs_writedata_i[1:0];
    end
  end

  // Read mux, registered; unmapped reads return zero
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && !ack_reg) begin
      avs_readdata_o <= 32'h00000000;
      case (avs_address_i[7:0] & 8'hf0)
        `OFS_OWNERSHIP:  avs_readdata_o[WIDTH-1:0] <= port_ownership_enable[port_sel];
        `OFS_FUNC_LOW:   avs_readdata_o[WIDTH-1:0] <= function_select_low[port_sel];
        `OFS_FUNC_HIGH:  avs_readdata_o[WIDTH-1:0] <= function_select_high[port_sel];
        `OFS_DRIVER_ON:  avs_readdata_o[WIDTH-1:0] <= output_driver_on[port_sel];
        `OFS_OUT_LEVEL:  avs_readdata_o[WIDTH-1:0] <= output_level[port_sel];
        // Level visible only where owned or interrupt enabled
        `OFS_PIN_VALUE:  avs_readdata_o[WIDTH-1:0] <= filt[port_sel] &
          (port_ownership_enable[port_sel] | pin_irq_enable[port_sel]);
        `OFS_PULLUP:     avs_readdata_o[WIDTH-1:0] <= pullup_on[port_sel];
        `OFS_IRQ_ENABLE: avs_readdata_o[WIDTH-1:0] <= pin_irq_enable[port_sel];
        `OFS_KIND_LOW:   avs_readdata_o[WIDTH-1:0] <= event_kind_low[port_sel];
        `OFS_KIND_HIGH:  avs_readdata_o[WIDTH-1:0] <= event_kind_high[port_sel];
        `OFS_FILTER_EN:  avs_readdata_o[WIDTH-1:0] <= input_filter_enable[port_sel];
        // Raw flags; only bits with interrupt enabled are trustworthy
        `OFS_EVENT_FLAGS: avs_readdata_o[WIDTH-1:0] <= pin_event_flags[port_sel];
        8'he0: begin
          if (avs_address_i[7:0] == `OFS_IRQ_STATUS)
            avs_readdata_o[1:0] <= irq_status_reg;
          else if (avs_address_i[7:0] == `OFS_IRQ_MASK)
            avs_readdata_o[1:0] <= irq_mask_reg;
        end
        default: avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

  // Wait until ack cycle; outputs all from flops
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_waitrequest_o <= 1'b1;
      pin0_out_o <= `RST_ZERO;
      pin0_oe_o <= `RST_ZERO;
      pin0_pullup_o <= `RST_ZERO;
      pin0_gpio_own_o <= `RST_PORT0_OWN;
      pin0_func_low_o <= `RST_ZERO;
      pin0_func_high_o <= `RST_ZERO;
      pin1_out_o <= `RST_ZERO;
      pin1_oe_o <= `RST_ZERO;
      pin1_pullup_o <= `RST_ZERO;
      pin1_gpio_own_o <= `RST_PORT1_OWN;
      pin1_func_low_o <= `RST_ZERO;
      pin1_func_high_o <= `RST_ZERO;
      pin0_irq_o <= `RST_ZERO;
      pin1_irq_o <= `RST_ZERO;
      irq_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack_reg);
      // Drivers follow port regs; mux outside uses func bits
      pin0_out_o <= output_level[0];
      pin0_oe_o <= output_driver_on[0] & port_ownership_enable[0];
      pin0_pullup_o <= pullup_on[0];
      pin0_gpio_own_o <= port_ownership_enable[0];
      pin0_func_low_o <= function_select_low[0];
      pin0_func_high_o <= function_select_high[0];
      pin1_out_o <= output_level[1];
      pin1_oe_o <= output_driver_on[1] & port_ownership_enable[1];
      pin1_pullup_o <= pullup_on[1];
      pin1_gpio_own_o <= port_ownership_enable[1];
      pin1_func_low_o <= function_select_low[1];
      pin1_func_high_o <= function_select_high[1];
      pin0_irq_o <= pin_event_flags[0] & pin_irq_enable[0];
      pin1_irq_o <= pin_event_flags[1] & pin_irq_enable[1];
      irq_o <= |(irq_status_reg & irq_mask_reg);
    end
  end

endmodule

// *** sim/pin_drive_model.sv ***
`timescale 1ns/1ps
// Far side of one port: external drivers and the pad itself
module pin_drive_model #(
  parameter WIDTH = 32
) (
  input  wire logic             clock_i,
  input  wire logic [WIDTH-1:0] out_i,
  input  wire logic [WIDTH-1:0] oe_i,
  input  wire logic [WIDTH-1:0] pullup_i,
  input  wire logic [WIDTH-1:0] ext_level_i,
  input  wire logic [WIDTH-1:0] ext_drive_i,
  output logic      [WIDTH-1:0] pin_o
);
  logic [WIDTH-1:0] last_reg = '0;
  // Floating unpulled bits flip so a stale level never looks valid
  always_comb pin_o = (oe_i & out_i) | (~oe_i & ext_drive_i & ext_level_i)
                    | (~oe_i & ~ext_drive_i & (pullup_i | ~last_reg));
  always @(posedge clock_i) last_reg <= pin_o;
endmodule

// *** sim/gpio_pin_event_chk.sv ***
`timescale 1ns/1ps
module gpio_pin_event_chk #(
  parameter WIDTH = 32
) (
  input wire logic             clock_i,
  input wire logic             arst_n_i,
  input wire logic [9:0]       avs_address_i,
  input wire logic             avs_read_i,
  input wire logic             avs_write_i,
  input wire logic [31:0]      avs_readdata_o,
  input wire logic             avs_waitrequest_o,
  input wire logic [WIDTH-1:0] pin0_oe_o,
  input wire logic [WIDTH-1:0] pin0_gpio_own_o,
  input wire logic [WIDTH-1:0] pin1_gpio_own_o,
  input wire logic [WIDTH-1:0] pin0_func_low_o,
  input wire logic [WIDTH-1:0] pin0_irq_o,
  input wire logic             irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Registered outputs trail the bus write by up to three edges
  sequence wr_recent;
    $past(avs_write_i, 1) || $past(avs_write_i, 2) || $past(avs_write_i, 3);
  endsequence
  sequence req_waiting;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  own0_reset_a: assert property ($rose(arst_n_i) |-> pin0_gpio_own_o == 32'hffffffff)
    else $error("port 0 ownership reset wrong");
  own1_reset_a: assert property ($rose(arst_n_i) |-> pin1_gpio_own_o == 32'h00000fff)
    else $error("port 1 ownership reset wrong");
  zero_reset_a: assert property ($rose(arst_n_i) |->
    pin0_oe_o == 0 && pin0_func_low_o == 0 && !irq_o) else $error("nonzero reset value");
  func_hold_a: assert property ($changed(pin0_func_low_o) |-> wr_recent)
    else $error("function select moved without a write");
  drive_hold_a: assert property ($changed(pin0_oe_o) |-> wr_recent)
    else $error("driver enable moved without a write");
  own_hold_a: assert property ($changed(pin0_gpio_own_o) |-> wr_recent)
    else $error("ownership moved without a write");
  flag_sticky_a: assert property (|($past(pin0_irq_o) & ~pin0_irq_o) |-> wr_recent)
    else $error("pin interrupt dropped without a write");
  irq_fall_a: assert property ($fell(irq_o) |-> wr_recent)
    else $error("interrupt dropped without a write");
  wait_pulse_a: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  answer_bound_a: assert property (req_waiting |-> ##[0:2] !avs_waitrequest_o)
    else $error("bus request not answered");
  unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i[7:4] == 4'h3 |-> avs_readdata_o == 32'h0) else $error("unmapped read nonzero");
endmodule
bind gpio_pin_event gpio_pin_event_chk #(.WIDTH(WIDTH)) gpio_pin_event_chk_i (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .pin0_oe_o(pin0_oe_o),
  .pin0_gpio_own_o(pin0_gpio_own_o), .pin1_gpio_own_o(pin1_gpio_own_o),
  .pin0_func_low_o(pin0_func_low_o), .pin0_irq_o(pin0_irq_o), .irq_o(irq_o));

// *** sim/gpio_pin_event_and_filter_bench.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module gpio_pin_event_and_filter_bench;
  logic        clock_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [9:0]  avs_address_i = 10'h000;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] lvl0 = 32'h00000000;
  logic [31:0] lvl1 = 32'h00000000;
  wire  [31:0] avs_readdata_o, p0, p1, out0, oe0, pu0, own0, fl0, fh0;
  wire  [31:0] out1, oe1, pu1, own1, fl1, fh1, irq0, irq1;
  wire         avs_waitrequest_o, irq_o;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          pw [3] = '{2, 6, 1};
  logic [7:0]  zoff [4] = '{8'h10, 8'h90, 8'ha0, 8'hc0};
  logic [31:0] d;

  gpio_pin_event gpio_pin_event_i (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pin0_i(p0), .pin1_i(p1),
    .pin0_out_o(out0), .pin0_oe_o(oe0), .pin0_pullup_o(pu0), .pin0_gpio_own_o(own0),
    .pin0_func_low_o(fl0), .pin0_func_high_o(fh0), .pin1_out_o(out1), .pin1_oe_o(oe1),
    .pin1_pullup_o(pu1), .pin1_gpio_own_o(own1), .pin1_func_low_o(fl1),
    .pin1_func_high_o(fh1), .pin0_irq_o(irq0), .pin1_irq_o(irq1), .irq_o(irq_o));
  pin_drive_model pins0_model (.clock_i(clock_i), .out_i(out0), .oe_i(oe0), .pullup_i(pu0),
    .ext_level_i(lvl0), .ext_drive_i(32'hffffffff), .pin_o(p0));
  pin_drive_model pins1_model (.clock_i(clock_i), .out_i(out1), .oe_i(oe1), .pullup_i(pu1),
    .ext_level_i(lvl1), .ext_drive_i(32'hffffffff), .pin_o(p1));

  // 50 MHz clock
  initial begin
    forever #10 clock_i = ~clock_i;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [9:0] a(input logic p, input logic [7:0] o);
    return {p, 1'b0, o};
  endfunction

  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic [9:0] adr, input logic w, input logic [31:0] wd);
    int n;
    @(posedge clock_i);
    avs_address_i <= adr;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= wd;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    d = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (avs_waitrequest_o !== 1'b0) begin
      bad_count++;
      complete_run;
    end
  endtask

  task automatic wr(input logic [9:0] adr, input logic [31:0] wd);
    bus(adr, 1'b1, wd);
  endtask

  task automatic rd(input logic [9:0] adr);
    bus(adr, 1'b0, 32'h0);
  endtask

  // Long enough for sample flop, filter and flag stages
  task automatic settle;
    repeat (12) @(posedge clock_i);
  endtask

  initial begin
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    rd(a(0, 8'h00)); `CHK("own0", 32'hffffffff, d)
    rd(a(1, 8'h00)); `CHK("own1", 32'h00000fff, d)
    rd(a(0, 8'hd0)); `CHK("flags0", 32'hffffffff, d)
    rd(a(1, 8'hd0)); `CHK("flags1", 32'h00000fff, d)
    for (int k = 0; k < 8; k++) begin
      rd(a(k[0], zoff[k>>1])); `CHK("zero", 32'h0, d)
    end
    wr(a(0, 8'h30), 32'hffffffff);
    rd(a(0, 8'h30)); `CHK("unmapped", 32'h0, d)
    $display("test reset done");
    // Zero writes and writes to the read location must not clear
    wr(a(0, 8'hd0), 32'hffffffff);
    wr(a(0, 8'hd8), 32'h0);
    rd(a(0, 8'hd0)); `CHK("noclr", 32'hffffffff, d)
    wr(a(1, 8'hd8), 32'h00000f0f);
    wr(a(0, 8'hd8), 32'hffffffff);
    rd(a(0, 8'hd0)); `CHK("clr0", 32'h0, d)
    rd(a(1, 8'hd0)); `CHK("clr1", 32'h000000f0, d)
    $display("test flag clear done");
    // Pin 1 toggles too but has no interrupt enable
    wr(a(0, 8'h90), 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(a(0, 8'ha0), 32'(k[0]));
      wr(a(0, 8'hb0), 32'(k[1]));
      wr(a(0, 8'hd8), 32'h3);
      lvl0 <= 32'h3;
      settle;
      rd(a(0, 8'hd0)); `CHK("rise", 32'(k < 2), d)
      lvl0 <= 32'h0;
      settle;
      rd(a(0, 8'hd0)); `CHK("fall", 32'(k != 3), d)
    end
    wr(a(0, 8'ha0), 32'h0);
    wr(a(0, 8'hb0), 32'h0);
    $display("test event kinds done");
    // Filter on: 2 and 6 cycle pulses; filter off: 1 cycle pulse
    for (int k = 0; k < 3; k++) begin
      wr(a(0, 8'h90), 32'h0);
      wr(a(0, 8'hc0), 32'(k < 2));
      wr(a(0, 8'h90), 32'h1);
      wr(a(0, 8'hd8), 32'h1);
      lvl0 <= 32'h1;
      repeat (pw[k]) @(posedge clock_i);
      lvl0 <= 32'h0;
      settle;
      rd(a(0, 8'hd0)); `CHK("filter", 32'(k > 0), d)
    end
    `CHK("irq0", 32'h00000001, irq0)
    $display("test filter done");
    // Port 1 event through status, mask and the interrupt line
    wr(a(0, 8'he0), 32'h3);
    wr(a(1, 8'h90), 32'h100);
    lvl1 <= 32'h100;
    settle;
    `CHK("irq_masked", 1'b0, irq_o)
    rd(a(0, 8'he0)); `CHK("status", 32'h2, d)
    wr(a(0, 8'he4), 32'h2);
    settle;
    `CHK("irq_on", 1'b1, irq_o)
    wr(a(0, 8'he0), 32'h2);
    settle;
    `CHK("irq_off", 1'b0, irq_o)
    rd(a(1, 8'hd0)); `CHK("flags1_ev", 32'h000001f0, d)
    `CHK("irq1", 32'h00000100, irq1)
    $display("test interrupt done");
    // Port 0 drives pins 4 to 7; the pad reads back with the filter off
    wr(a(0, 8'h50), 32'h000000a0);
    wr(a(0, 8'h44), 32'h000000f0);
    wr(a(0, 8'h70), 32'h0000000f);
    wr(a(0, 8'h14), 32'h00000001);
    wr(a(0, 8'h24), 32'h00000002);
    settle;
    `CHK("out0", 32'h000000a0, out0)
    `CHK("pu0", 32'h0000000f, pu0)
    `CHK("fsel0_low", 32'h00000001, fl0)
    `CHK("fsel0_high", 32'h00000002, fh0)
    `CHK("oe0_owned", 32'h000000f0, oe0)
    rd(a(0, 8'h60)); `CHK("pinval", 32'h000000a0, d)
    wr(a(0, 8'h08), 32'h00000010);
    settle;
    `CHK("oe0_freed", 32'h000000e0, oe0)
    `CHK("own0_freed", 32'hffffffef, own0)
    $display("test port outputs done");
    // Park pins with drivers off before moving the function mux
    wr(a(1, 8'h48), 32'h00030000);
    wr(a(1, 8'h04), 32'h00030000);
    settle;
    `CHK("own_set", 32'h00030fff, own1)
    for (int k = 0; k < 4; k++) begin
      wr(a(1, 8'h10), k[0] ? 32'h00030000 : 32'h0);
      wr(a(1, 8'h20), k[1] ? 32'h00030000 : 32'h0);
      settle;
      `CHK("fsel", k[1:0], {fh1[17], fl1[16]})
      `CHK("tristate", 2'b00, oe1[17:16])
    end
    wr(a(1, 8'h08), 32'h00030000);
    settle;
    `CHK("own_clr", 32'h00000fff, own1)
    $display("test function select done");
    complete_run;
  end
endmodule
